//--- pkg/oam_defines.svh
// Opcode patterns, field positions and widths for the OR and move executor
`ifndef OAM_DEFINES_SVH
`define OAM_DEFINES_SVH
`define OAM_INSN_W 12
`define OAM_DATA_W 8
`define OAM_ADDR_W 5
`define OAM_OP_LIT_HI 11
`define OAM_OP_LIT_LO 8
`define OAM_OP_OR_LIT 4'hD
`define OAM_OP_LOAD_LIT 4'hC
`define OAM_OP_REG_HI 11
`define OAM_OP_REG_LO 6
`define OAM_OP_OR_FILE 6'h04
`define OAM_OP_MOVE_FILE 6'h08
`define OAM_OP_STORE_HI 11
`define OAM_OP_STORE_LO 5
`define OAM_OP_STORE 7'h01
`define OAM_DEST_BIT 5
`define OAM_ACC_RST 8'h00
`define OAM_ZERO_RST 1'h0
`endif

//--- pkg/oam_pkg.sv
// Types for the OR and move executor
package oam_pkg;
    typedef enum logic [5:0] {
        OAM_NONE = 6'h01,
        OAM_OR_LIT = 6'h02,
        OAM_OR_FILE = 6'h04,
        OAM_MOVE_FILE = 6'h08,
        OAM_LOAD_LIT = 6'h10,
        OAM_STORE = 6'h20
    } oam_op_type;

    typedef struct packed {
        logic [7:0] acc;
        logic zero;
    } oam_state_type;
endpackage

//--- rtl/oam_exec.sv
// Decoder and executor for the OR and move instructions
`timescale 1ns/1ps
`default_nettype none
`include "oam_defines.svh"

module oam_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Instruction issue, one per enabled cycle
    input wire logic insn_valid,
    input wire logic [11:0] insn,
    // File register read port, combinational
    output logic [4:0] file_addr,
    input wire logic [7:0] file_rdata,
    // File register write strobe
    output logic file_we,
    output logic [7:0] file_wdata,
    // Core state
    output logic [7:0] acc,
    output logic zero_flag,
    output logic insn_known
);
    // Timing in brief:
    // the word is decoded and executed in the cycle it is offered,
    // the file write strobe and data leave combinationally,
    // accumulator and zero flag change at the closing edge.
    // The file read is assumed combinational at file_addr, so the
    // read, the operation and the write-back share one cycle.
    // Reset does not gate the write strobe; the issuing side
    // must keep insn_valid low while reset is applied.

    // Registered core state and its next value
    oam_pkg::oam_state_type state_q;
    oam_pkg::oam_state_type state_d;

    // Decoded operation, one-hot
    oam_pkg::oam_op_type op;

    // Opcode fields of the three encoding groups
    logic [3:0] op_lit_field;
    logic [5:0] op_reg_field;
    logic [6:0] op_store_field;

    // Raw pattern matches, before priority
    logic hit_or_lit;
    logic hit_load_lit;
    logic hit_or_file;
    logic hit_move_file;
    logic hit_store;

    // Operand fields
    logic dest_file;
    logic [7:0] literal;

    // Candidate results, formed ahead of the select
    logic [7:0] or_lit_val;
    logic [7:0] or_file_val;
    logic or_lit_zero;
    logic or_file_zero;
    logic rdata_zero;

    // Selected result, also the file write data
    logic [7:0] result;

    // Split the word into its opcode groups
    assign op_lit_field = insn[`OAM_OP_LIT_HI:`OAM_OP_LIT_LO];
    assign op_reg_field = insn[`OAM_OP_REG_HI:`OAM_OP_REG_LO];
    assign op_store_field = insn[`OAM_OP_STORE_HI:`OAM_OP_STORE_LO];

    // Match each encoding on its own field
    assign hit_or_lit = (op_lit_field == `OAM_OP_OR_LIT);
    assign hit_load_lit = (op_lit_field == `OAM_OP_LOAD_LIT);
    assign hit_or_file = (op_reg_field == `OAM_OP_OR_FILE);
    assign hit_move_file = (op_reg_field == `OAM_OP_MOVE_FILE);
    assign hit_store = (op_store_field == `OAM_OP_STORE);

    // Priority select; the patterns are disjoint, so the order
    // only keeps the result one-hot if the word is corrupt
    always_comb begin
        op = oam_pkg::OAM_NONE;
        if (hit_or_lit) begin
            op = oam_pkg::OAM_OR_LIT;
        end else if (hit_load_lit) begin
            op = oam_pkg::OAM_LOAD_LIT;
        end else if (hit_or_file) begin
            op = oam_pkg::OAM_OR_FILE;
        end else if (hit_move_file) begin
            op = oam_pkg::OAM_MOVE_FILE;
        end else if (hit_store) begin
            op = oam_pkg::OAM_STORE;
        end
    end

    // Operand fields shared by every form
    assign literal = insn[7:0];
    assign dest_file = insn[`OAM_DEST_BIT];
    assign file_addr = insn[4:0];

    // Candidate results and their zero tests
    assign or_lit_val = state_q.acc | literal;
    assign or_file_val = state_q.acc | file_rdata;
    assign or_lit_zero = (or_lit_val == 8'h00);
    assign or_file_zero = (or_file_val == 8'h00);
    assign rdata_zero = (file_rdata == 8'h00);

    // Execute: next state and file write, all in one cycle
    always_comb begin
        state_d = state_q;
        result = 8'h00;
        file_we = 1'b0;
        if (insn_valid) begin
            case (op)
                // OR literal: accumulator only
                oam_pkg::OAM_OR_LIT: begin
                    result = or_lit_val;
                    state_d.acc = or_lit_val;
                    state_d.zero = or_lit_zero;
                end
                // OR file: zero follows the result for either destination
                oam_pkg::OAM_OR_FILE: begin
                    result = or_file_val;
                    state_d.zero = or_file_zero;
                    if (dest_file) begin
                        file_we = 1'b1;
                    end else begin
                        state_d.acc = or_file_val;
                    end
                end
                // Move file: a move onto itself is a zero test
                oam_pkg::OAM_MOVE_FILE: begin
                    result = file_rdata;
                    state_d.zero = rdata_zero;
                    if (dest_file) begin
                        file_we = 1'b1;
                    end else begin
                        state_d.acc = file_rdata;
                    end
                end
                // Load literal: flags left alone
                oam_pkg::OAM_LOAD_LIT: begin
                    state_d.acc = literal;
                end
                // Store: write the accumulator, flags left alone
                oam_pkg::OAM_STORE: begin
                    result = state_q.acc;
                    file_we = 1'b1;
                end
                // Unknown words change nothing
                default: begin
                    result = 8'h00;
                end
            endcase
        end
    end

    // Write data travels with the strobe in the same cycle
    assign file_wdata = result;

    // Register the state each cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q.acc <= `OAM_ACC_RST;
            state_q.zero <= `OAM_ZERO_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // Core state straight from the register
    assign acc = state_q.acc;
    assign zero_flag = state_q.zero;

    // Flags a valid word that is one of the five forms
    assign insn_known = insn_valid && (op != oam_pkg::OAM_NONE);
endmodule // oam_exec
`default_nettype wire

//--- bench/oam_exec_chk.sv
// Executor checker
`timescale 1ns/1ps
`default_nettype none
module oam_chk (
    input wire logic clk, sys_rst, insn_valid, file_we, zero_flag,
    input wire logic [11:0] insn,
    input wire logic [7:0] file_rdata, file_wdata, acc
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic [6:0] op=insn_valid ? insn[11:5] : 7'h7F;
    property p_orw; op[6:1]==6'h04 |-> file_we==op[0]; endproperty
    a_orw: assert property (p_orw) else $error("orw");
    property p_mvz; op[6:1]==6'h08 |=> zero_flag==!$past(file_rdata); endproperty
    a_mvz: assert property (p_mvz) else $error("mvz");
    property p_sto; op==7'h01 |-> file_we && file_wdata==acc ##1 $stable(zero_flag); endproperty
    a_sto: assert property (p_sto) else $error("sto");
    property p_ldl; op[6:3]==4'hC |=> acc==$past(insn[7:0]) && $stable(zero_flag); endproperty
    a_ldl: assert property (p_ldl) else $error("ldl");
    property p_orl; op[6:3]==4'hD |=> acc==($past(acc)|$past(insn[7:0])) && zero_flag==(acc==8'h00); endproperty
    a_orl: assert property (p_orl) else $error("orl");
    property p_orf; op[6:1]==6'h04 |-> file_wdata==(acc|file_rdata); endproperty
    a_orf: assert property (p_orf) else $error("orf");
    property p_mvd; op[6:1]==6'h08 |-> file_we==op[0] && file_wdata==file_rdata; endproperty
    a_mvd: assert property (p_mvd) else $error("mvd");
endmodule // oam_chk
bind oam_exec oam_chk u_chk (.*);
`default_nettype wire

//--- bench/tb_top.sv
// Executor bench
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk=1'b0, sys_rst=1'b1, insn_valid=1'b0;
    logic file_we, zero_flag, insn_known;
    logic [11:0] insn=12'h000;
    logic [4:0] file_addr;
    logic [7:0] file_wdata, acc;
    wire logic [7:0] file_rdata={3'h0,file_addr};
    int failures=0, tests_run=0, cyc=0;
    oam_exec dut (.*);
    initial forever #4 clk=~clk;
    always @(posedge clk) if (++cyc>99) close_out;
    task chk(input logic [9:0] s, e);
        tests_run++;
        if (s!==e) begin
            failures++;
            $display("ERROR %0t mismatch seen %h expected %h", $time, s, e);
        end
    endtask
    // Issue one word; w is {known, write strobe, write data when strobed}
    task st(input logic [11:0] i, input logic [8:0] e, input logic [9:0] w);
        @(posedge clk) insn<=i;
        insn_valid<=1'b1;
        #1 chk({insn_known, file_we, file_we ? file_wdata : 8'h00}, w);
        @(posedge clk) insn_valid<=1'b0;
        #1 chk({1'b0, zero_flag, acc}, {1'b0, e});
    endtask
    task close_out;
        failures+=cyc>99;
        $display("%0d/%0d failed", failures, tests_run);
        if (failures==0 && tests_run>0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task t_lit;
        st(12'hD00, 9'h100, 10'h200);
        st(12'hC9A, 9'h19A, 10'h200);
        st(12'hD35, 9'h0BF, 10'h200);
        $display("lit done");
    endtask
    task t_reg;
        st(12'h220, 9'h1BF, 10'h300);
        st(12'h210, 9'h010, 10'h200);
        st(12'h105, 9'h015, 10'h200);
        st(12'h123, 9'h015, 10'h317);
        st(12'h030, 9'h015, 10'h315);
        $display("reg done");
    endtask
    task t_unk;
        st(12'hF00, 9'h015, 10'h000);
        st(12'h221, 9'h015, 10'h301);
        $display("unknown done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        sys_rst<=1'b0;
        t_lit;
        t_reg;
        t_unk;
        close_out;
    end
endmodule // tb_top
`default_nettype wire
